// ===== rtl/fac_top.sv
// Notes on behaviour
// - Protection address at D34, bus address D38
// - Only privileged software may read or write
// - Protection fault stores actual faulting address
// - Stored address may lie anywhere in access
// - Protection address meaningful only while valid
// - Bus fault stores the instruction's requested address
// - Bus address meaningful only while valid
`timescale 1ns/100ps
`default_nettype none

module fac_top
  import fac_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire fac_req_t    req_i,
  output fac_rsp_t         rsp_o,
  input  wire fac_fault_t  prot_fault_i,
  input  wire fac_fault_t  bus_fault_i,
  input  wire logic        prot_valid_clr_i,
  input  wire logic        bus_valid_clr_i,
  output logic             protection_address_valid_o,
  output logic             bus_error_address_valid_o,
  output logic      [31:0] memory_protection_fault_address_o,
  output logic      [31:0] bus_error_address_o
);

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  fac_dec_t    dec;
  logic        granted;
  logic        refused;
  logic        prot_sw_wr;
  logic        bus_sw_wr;
  logic [31:0] prot_addr;
  logic [31:0] bus_addr;
  logic        prot_valid;
  logic        bus_valid;

  // Select the addressed register from the offset
  always_comb begin
    dec = FAC_DEC_NONE;
    if (req_i.sel) begin
      case (req_i.offset)
        FAC_OFS_PROT_ADDR: dec = FAC_DEC_PROT;
        FAC_OFS_BUS_ADDR:  dec = FAC_DEC_BUS;
        default:           dec = FAC_DEC_NONE;
      endcase
    end
  end

  // Privilege check on every mapped access
  assign granted = (dec != FAC_DEC_NONE) && req_i.priv;
  assign refused = (dec != FAC_DEC_NONE) && !req_i.priv;

  // Write strobes into the two slots
  assign prot_sw_wr = granted && req_i.wr && (dec == FAC_DEC_PROT);
  assign bus_sw_wr  = granted && req_i.wr && (dec == FAC_DEC_BUS);

  // ---------------------------------------------------------------
  // Capture slots
  // ---------------------------------------------------------------
  // Protection fault keeps the failing aligned access address,
  // which may be any byte of the requested span
  fac_addr_slot u_prot_slot (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .capture_i      (prot_fault_i.fault),
    .capture_addr_i (prot_fault_i.act_addr),
    .sw_wr_i        (prot_sw_wr),
    .sw_wdata_i     (req_i.wdata),
    .valid_clr_i    (prot_valid_clr_i),
    .addr_o         (prot_addr),
    .valid_o        (prot_valid)
  );

  // Bus fault keeps the address the instruction asked for
  fac_addr_slot u_bus_slot (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .capture_i      (bus_fault_i.fault),
    .capture_addr_i (bus_fault_i.req_addr),
    .sw_wr_i        (bus_sw_wr),
    .sw_wdata_i     (req_i.wdata),
    .valid_clr_i    (bus_valid_clr_i),
    .addr_o         (bus_addr),
    .valid_o        (bus_valid)
  );

  // ---------------------------------------------------------------
  // Answer path
  // ---------------------------------------------------------------
  logic        ack_reg;
  logic        ack_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Read data shows the value held at the access edge
  always_comb begin
    ack_next   = granted;
    err_next   = refused;
    rdata_next = FAC_RDATA_RST;
    if (granted && !req_i.wr) begin
      case (dec)
        FAC_DEC_PROT: rdata_next = prot_addr;
        FAC_DEC_BUS:  rdata_next = bus_addr;
        default:      rdata_next = FAC_RDATA_RST;
      endcase
    end
  end

  // Answer registers, one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= FAC_RDATA_RST;
    end else if (ce_i) begin
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rsp_o.ack   = ack_reg;
  assign rsp_o.err   = err_reg;
  assign rsp_o.rdata = rdata_reg;

  // Valid flags qualify the captured addresses
  assign protection_address_valid_o        = prot_valid;
  assign bus_error_address_valid_o         = bus_valid;
  assign memory_protection_fault_address_o = prot_addr;
  assign bus_error_address_o               = bus_addr;

endmodule

`default_nettype wire

// ===== rtl/fac_pkg.sv
package fac_pkg;

  // ---------------------------------------------------------------
  // Register map (offsets in the system control space)
  // ---------------------------------------------------------------
  localparam logic [31:0] FAC_SCS_BASE         = 32'hE000E000;
  localparam logic [11:0] FAC_OFS_PROT_ADDR    = 12'hD34;
  localparam logic [11:0] FAC_OFS_BUS_ADDR     = 12'hD38;

  // ---------------------------------------------------------------
  // Reset values (documented as undefined, zero chosen)
  // ---------------------------------------------------------------
  localparam logic [31:0] FAC_ADDR_RST         = 32'h00000000;
  localparam logic [31:0] FAC_RDATA_RST        = 32'h00000000;
  localparam logic        FAC_VALID_RST        = 1'b0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Register access from the system control space decoder
  typedef struct packed {
    logic        sel;     // Access strobe, one cycle
    logic        wr;      // 1 write, 0 read
    logic        priv;    // Requester is privileged
    logic [11:0] offset;  // Offset from the system control space base
    logic [31:0] wdata;
  } fac_req_t;

  // Answer to a register access
  typedef struct packed {
    logic        ack;     // Mapped and granted
    logic        err;     // Mapped but refused
    logic [31:0] rdata;
  } fac_rsp_t;

  // Fault report from the load/store path
  typedef struct packed {
    logic        fault;     // One-cycle fault pulse
    logic [31:0] req_addr;  // Address the instruction asked for
    logic [31:0] act_addr;  // Address of the aligned access that failed
  } fac_fault_t;

  // Access decode result
  typedef enum logic [1:0] {
    FAC_DEC_NONE,
    FAC_DEC_PROT,
    FAC_DEC_BUS
  } fac_dec_t;

endpackage

// ===== rtl/fac_addr_slot.sv
`timescale 1ns/100ps
`default_nettype none

module fac_addr_slot
  import fac_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        capture_i,
  input  wire logic [31:0] capture_addr_i,
  input  wire logic        sw_wr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        valid_clr_i,
  output logic      [31:0] addr_o,
  output logic             valid_o
);

  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic        valid_reg;
  logic        valid_next;

  // ---------------------------------------------------------------
  // Next state: a fault beats a software write and a flag clear
  // ---------------------------------------------------------------
  always_comb begin
    addr_next  = addr_reg;
    valid_next = valid_reg;
    if (capture_i) begin
      addr_next  = capture_addr_i;
      valid_next = 1'b1;
    end else begin
      if (sw_wr_i) begin
        addr_next = sw_wdata_i;
      end
      if (valid_clr_i) begin
        valid_next = 1'b0;
      end
    end
  end

  // Registers, frozen while the clock enable is low and reset is not asserted
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_reg  <= FAC_ADDR_RST;
      valid_reg <= FAC_VALID_RST;
    end else if (ce_i) begin
      addr_reg  <= addr_next;
      valid_reg <= valid_next;
    end
  end

  assign addr_o  = addr_reg;
  assign valid_o = valid_reg;

endmodule

`default_nettype wire

// ===== tb/fac_lsu_model.sv
`timescale 1ns/100ps
`default_nettype none
module fac_lsu_model
  import fac_pkg::*;
(
  input  wire logic [1:0]  go_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic [31:0] act_addr_i,
  output fac_fault_t       prot_fault_o,
  output fac_fault_t       bus_fault_o
);
  // Fault reports; address lines carry junk while idle
  always_comb begin
    prot_fault_o = '{go_i[0], req_addr_i, act_addr_i};
    bus_fault_o  = '{go_i[1], req_addr_i, act_addr_i};
    if (go_i == 2'h0) begin
      prot_fault_o.act_addr = ~act_addr_i;
      bus_fault_o.req_addr  = ~req_addr_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fac_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module fac_top_props
  import fac_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire fac_req_t    req_i,
  input wire fac_rsp_t    rsp_o,
  input wire fac_fault_t  prot_fault_i,
  input wire fac_fault_t  bus_fault_i,
  input wire logic        prot_valid_clr_i,
  input wire logic        bus_valid_clr_i,
  input wire logic        protection_address_valid_o,
  input wire logic        bus_error_address_valid_o,
  input wire logic [31:0] memory_protection_fault_address_o,
  input wire logic [31:0] bus_error_address_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic hp = ce_i && req_i.sel && req_i.offset == FAC_OFS_PROT_ADDR;
  wire logic hb = ce_i && req_i.sel && req_i.offset == FAC_OFS_BUS_ADDR;
  sequence prot_seen; ce_i && prot_fault_i.fault; endsequence
  sequence bus_seen; ce_i && bus_fault_i.fault; endsequence
  map_ack_a: assert property ((hp || hb) && req_i.priv |=> rsp_o.ack)
    else $error("granted access not acknowledged");
  priv_err_a: assert property ((hp || hb) && !req_i.priv |=>
    rsp_o.err && !rsp_o.ack && rsp_o.rdata == 32'h0) else $error("no refusal");
  prot_act_a: assert property (prot_seen |=>
    protection_address_valid_o &&
    memory_protection_fault_address_o == $past(prot_fault_i.act_addr))
    else $error("protection address wrong");
  prot_clr_a: assert property (ce_i && prot_valid_clr_i &&
    !prot_fault_i.fault |=> !protection_address_valid_o)
    else $error("protection valid not cleared");
  bus_clr_a: assert property (ce_i && bus_valid_clr_i &&
    !bus_fault_i.fault |=> !bus_error_address_valid_o)
    else $error("bus valid not cleared");
  rd_prot_a: assert property (hp && req_i.priv && !req_i.wr |=>
    rsp_o.rdata == $past(memory_protection_fault_address_o)) else $error("rd");
  bus_req_a: assert property (bus_seen |=> bus_error_address_valid_o &&
    bus_error_address_o == $past(bus_fault_i.req_addr)) else $error("bus addr");
  rd_bus_a: assert property (hb && req_i.priv && !req_i.wr |=>
    rsp_o.rdata == $past(bus_error_address_o)) else $error("bus read wrong");
  prot_hold_a: assert property (!prot_fault_i.fault &&
    !(hp && req_i.wr && req_i.priv)
    |=> $stable(memory_protection_fault_address_o)) else $error("not held");
  bus_hold_a: assert property (!bus_fault_i.fault &&
    !(hb && req_i.wr && req_i.priv)
    |=> $stable(bus_error_address_o)) else $error("bus address not held");
endmodule
bind fac_top fac_top_props props_u (.ref_clk_i, .rst_i, .ce_i, .req_i, .rsp_o,
  .prot_fault_i, .bus_fault_i, .prot_valid_clr_i, .bus_valid_clr_i,
  .protection_address_valid_o,
  .bus_error_address_valid_o, .memory_protection_fault_address_o,
  .bus_error_address_o);
`default_nettype wire

// ===== tb/fac_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fac_top_tb_top
  import fac_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  fac_req_t    req       = '0;
  fac_rsp_t    rsp;
  fac_fault_t  pf, bf;
  logic [1:0]  go        = 2'h0;
  logic [1:0]  clr       = 2'h0;
  logic [31:0] ra        = 32'h0;
  logic [31:0] aa        = 32'h0;
  logic        ce        = 1'b1;
  fac_rsp_t    ans;
  logic        pv, bv;
  logic [31:0] pa, ba;
  int          failures  = 0;
  int          n_tests   = 0;
  // Clock and far-side model
  always #5 ref_clk_i = ~ref_clk_i;
  fac_lsu_model lsu_u (.go_i(go), .req_addr_i(ra), .act_addr_i(aa),
    .prot_fault_o(pf), .bus_fault_o(bf));
  fac_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .req_i(req), .rsp_o(rsp), .prot_fault_i(pf), .bus_fault_i(bf),
    .prot_valid_clr_i(clr[0]), .bus_valid_clr_i(clr[1]),
    .protection_address_valid_o(pv), .bus_error_address_valid_o(bv),
    .memory_protection_fault_address_o(pa), .bus_error_address_o(ba));
  task automatic print_verdict();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register access; answer taken while it stands, then one idle cycle
  task automatic acc(input logic w, p, input logic [11:0] o,
                     input logic [31:0] d, output fac_rsp_t r);
    req = '{1'b1, w, p, o, d};
    @(negedge ref_clk_i);
    r = rsp;
    req.sel = 1'b0;
    @(negedge ref_clk_i);
  endtask
  // One fault pulse, then one idle cycle
  task automatic fire(input logic [1:0] k, input logic [31:0] r, a);
    go = k;
    ra = r;
    aa = a;
    @(negedge ref_clk_i);
    go = 2'h0;
    @(negedge ref_clk_i);
  endtask
  initial begin
    #200us;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("pv_rst", 32'h0, 32'(pv));
    chk("pa_rst", 32'h0, pa);
    fire(2'h1, 32'h2000_1001, 32'h2000_1003);
    chk("pa", 32'h2000_1003, pa);
    chk("pv", 32'h1, 32'(pv));
    chk("bv", 32'h0, 32'(bv));
    fire(2'h2, 32'h4000_0002, 32'h4000_0000);
    chk("ba", 32'h4000_0002, ba);
    chk("bv", 32'h1, 32'(bv));
    acc(1'b0, 1'b1, FAC_OFS_PROT_ADDR, 32'h0, ans);
    chk("ack", 32'h1, 32'(ans.ack));
    chk("rd_p", 32'h2000_1003, ans.rdata);
    acc(1'b0, 1'b1, FAC_OFS_BUS_ADDR, 32'h0, ans);
    chk("rd_b", 32'h4000_0002, ans.rdata);
    acc(1'b1, 1'b0, FAC_OFS_BUS_ADDR, 32'h1234_5678, ans);
    chk("err", 32'h1, 32'(ans.err));
    chk("ba_kept", 32'h4000_0002, ba);
    acc(1'b0, 1'b0, FAC_OFS_PROT_ADDR, 32'h0, ans);
    chk("rd_unpriv", 32'h0, ans.rdata);
    acc(1'b0, 1'b1, 12'hD3C, 32'h0, ans);
    chk("unmapped", 32'h0, 32'({ans.ack, ans.err}));
    acc(1'b1, 1'b1, FAC_OFS_PROT_ADDR, 32'h5A5A_A5A5, ans);
    chk("pa_wr", 32'h5A5A_A5A5, pa);
    chk("pv_wr", 32'h1, 32'(pv));
    clr = 2'h3;
    @(negedge ref_clk_i);
    clr = 2'h0;
    chk("pv_clr", 32'h0, 32'(pv));
    chk("bv_clr", 32'h0, 32'(bv));
    chk("pa_held", 32'h5A5A_A5A5, pa);
    // Both faults against both clears: the set wins
    clr = 2'h3;
    go  = 2'h3;
    ra  = 32'h3000_0010;
    aa  = 32'h3000_0012;
    @(negedge ref_clk_i);
    clr = 2'h0;
    go  = 2'h0;
    @(negedge ref_clk_i);
    chk("pv_set", 32'h1, 32'(pv));
    chk("bv_set", 32'h1, 32'(bv));
    fire(2'h1, 32'h3000_0020, 32'h3000_0021);
    chk("pa_last", 32'h3000_0021, pa);
    chk("ba_both", 32'h3000_0010, ba);
    // Clock enable low: a fault leaves no trace
    ce = 1'b0;
    fire(2'h1, 32'h7000_0007, 32'h7000_0007);
    ce = 1'b1;
    chk("pa_frozen", 32'h3000_0021, pa);
    // Reset in mid-run clears both slots
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("pa_rst2", 32'h0, pa);
    chk("bv_rst2", 32'h0, 32'(bv));
    acc(1'b0, 1'b1, FAC_OFS_BUS_ADDR, 32'h0, ans);
    chk("rd_rst2", 32'h0, ans.rdata);
    print_verdict();
  end
endmodule
`default_nettype wire
